// file: bra_ctrl.sv
// What this block does
// - Error plus halt ends cycle, strobes off
// - Rerun same cycle after both negate
// - Far side negates error before S2
// - Request with retry grants bus first
// - Locked sequence retries each cycle, lock held
// - No grant while locked; error plus request
// - Halt alone stops after current word
// - Halt holds external cycles until it negates
// - Error during halt becomes a retry
// - Halted: data floats, address held steady
// - Granted away floats; restored on return
// - Arbitration accepted normal, halted, double fault
// - Request, grant, acknowledge; device yields to pending grants, not to one issued as its cycle starts
// - Grant only at transfer end, unlocked
// - Master holds acknowledge while owning bus
// - Take bus on grant, acknowledge inactive
// - Drop grant after acknowledge; regrant if pending
// - Arbiter idle while request, acknowledge negated
// - Test pin low at reset: slave mode
// - Show off: address shown, strobes off
// - Show on: data strobe, internal data out
// - Byte write drives byte on both lanes
// - Retry forever; double fault still arbitrates
`timescale 1ns/100ps
`default_nettype none
module bra_ctrl (
   input  wire logic                       clk_sys,
   input  wire logic                       rstn,
   input  wire logic                       req_valid,
   input  wire logic                       req_internal,
   input  wire logic                       req_write,
   input  wire logic                       req_locked,
   input  wire logic [bra_pkg::ADDR_W-1:0] req_addr,
   input  wire logic [bra_pkg::FC_W-1:0]   req_fc,
   input  wire logic [bra_pkg::SIZ_W-1:0]  req_size,
   input  wire logic [bra_pkg::DATA_W-1:0] req_wdata,
   input  wire logic [1:0]                 show_cycle_field,
   input  wire logic                       double_fault,
   output logic                            req_ready,
   output logic                            done,
   output logic                            done_error,
   output logic [bra_pkg::DATA_W-1:0]      rdata,
   output logic                            halted,
   output logic                            slave_mode,
   output logic                            int_stall,
   bra_if.dev                              bus
);
   import bra_pkg::*;

   typedef enum logic [2:0] {CY_IDLE, CY_RUN, CY_WAITNEG, CY_SYNC, CY_HALT} bra_cyc_type;
   typedef enum logic [1:0] {AR_IDLE, AR_GRANT, AR_OWNED, AR_GAP} bra_arb_type;

   bra_cyc_type         cyc_ff;
   bra_arb_type         arb_ff;
   logic [3:0]          s1_ff;
   logic [3:0]          s2_ff;
   logic                bus_error_in_s;
   logic                halt_s;
   logic                br_s;
   logic                bga_s;
   logic                busy_ff;
   logic                int_ff;
   logic                wr_ff;
   logic                lock_ff;
   logic [ADDR_W-1:0]   addr_ff;
   logic [FC_W-1:0]     fc_ff;
   logic [SIZ_W-1:0]    siz_ff;
   logic [DATA_W-1:0]   wdat_ff;
   logic [1:0]          cnt_ff;
   logic                first_ff;
   logic                grant_ff;
   logic                away_ff;
   logic                as_ff;
   logic                ds_ff;
   logic                doe_ff;
   logic                show_on;
   logic                bus_free;

   function automatic logic [DATA_W-1:0] lane_dup(input logic [DATA_W-1:0] d, input logic [1:0] s);
      lane_dup = (s == SIZ_BYTE) ? {d[7:0], d[7:0]} : d;
   endfunction

   // =========================================
   // Synchronisers
   always_ff @(posedge clk_sys) begin
      s1_ff <= {bus.bus_error_in_n, bus.halt_n, bus.bus_request_n, bus.grant_acknowledge_n};
      s2_ff <= s1_ff;
   end
   assign bus_error_in_s  = !s2_ff[3];
   assign halt_s  = !s2_ff[2];
   assign br_s    = !s2_ff[1];
   assign bga_s   = !s2_ff[0];
   assign show_on = (show_cycle_field == SHOW_ON) || (show_cycle_field == SHOW_ON_STALL);
   assign bus_free = (cyc_ff == CY_IDLE || cyc_ff == CY_HALT || cyc_ff == CY_WAITNEG) && !lock_ff;

   // =========================================
   // Strap capture
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         first_ff   <= 1'b1;
         slave_mode <= 1'b0;
      end else if (first_ff) begin
         first_ff   <= 1'b0;
         slave_mode <= !bus.factory_test_pin_n;
      end
   end

   // =========================================
   // Cycle sequencer
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         cyc_ff <= CY_IDLE;
         cnt_ff <= '0;
      end else begin
         unique case (cyc_ff)
            CY_IDLE: begin
               if (busy_ff && !away_ff && arb_ff == AR_IDLE && !double_fault) begin
                  if (int_ff) begin
                     cyc_ff <= CY_RUN;
                  end else if (!halt_s) begin
                     cyc_ff <= CY_RUN;
                  end
               end
            end
            CY_RUN: begin
               if (int_ff) begin
                  cyc_ff <= CY_IDLE;
               end else if (bus_error_in_s && halt_s) begin
                  cyc_ff <= CY_WAITNEG;
               end else if (bus_error_in_s && br_s && lock_ff) begin
                  cyc_ff <= CY_WAITNEG;
               end else if (bus_error_in_s) begin
                  cyc_ff <= CY_IDLE;
               end else if (!bus.transfer_acknowledge_n) begin
                  cyc_ff <= halt_s ? CY_HALT : CY_IDLE;
               end
            end
            CY_WAITNEG: begin
               if (!bus_error_in_s && !halt_s && !away_ff && !br_s) begin
                  cyc_ff <= CY_SYNC;
                  cnt_ff <= SYNC_DLY_CNT;
               end
            end
            CY_SYNC: begin
               if (cnt_ff == '0) begin
                  cyc_ff <= CY_RUN;
               end else begin
                  cnt_ff <= cnt_ff - 2'h1;
               end
            end
            CY_HALT: begin
               if (!halt_s) begin
                  cyc_ff <= CY_IDLE;
               end else if (busy_ff && int_ff && !away_ff && !double_fault) begin
                  cyc_ff <= CY_RUN;
               end
            end
         endcase
      end
   end

   // =========================================
   // Held cycle attributes
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         busy_ff <= 1'b0;
         int_ff  <= 1'b0;
         wr_ff   <= 1'b0;
         lock_ff <= 1'b0;
         addr_ff <= '0;
         fc_ff   <= '0;
         siz_ff  <= '0;
         wdat_ff <= '0;
      end else if (req_valid && req_ready) begin
         busy_ff <= 1'b1;
         int_ff  <= req_internal;
         wr_ff   <= req_write;
         lock_ff <= req_locked;
         addr_ff <= req_addr;
         fc_ff   <= req_fc;
         siz_ff  <= req_size;
         wdat_ff <= lane_dup(req_wdata, req_size);
      end else if (cyc_ff == CY_RUN && (int_ff || (!bus_error_in_s && !bus.transfer_acknowledge_n))) begin
         busy_ff <= 1'b0;
         lock_ff <= req_locked;
      end else if (cyc_ff == CY_RUN && bus_error_in_s && !halt_s && !(br_s && lock_ff)) begin
         busy_ff <= 1'b0;
         lock_ff <= req_locked;
      end
   end

   // =========================================
   // Arbiter
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         arb_ff   <= AR_IDLE;
         grant_ff <= 1'b0;
      end else begin
         unique case (arb_ff)
            AR_IDLE: begin
               if (br_s && bus_free && !int_stall) begin
                  arb_ff   <= AR_GRANT;
                  grant_ff <= 1'b1;
               end
            end
            AR_GRANT: begin
               if (bga_s) begin
                  arb_ff   <= AR_OWNED;
                  grant_ff <= 1'b0;
               end else if (!br_s) begin
                  arb_ff   <= AR_IDLE;
                  grant_ff <= 1'b0;
               end
            end
            AR_OWNED: begin
               if (br_s) begin
                  arb_ff   <= AR_GAP;
                  grant_ff <= 1'b1;
               end else if (!bga_s) begin
                  arb_ff <= AR_IDLE;
               end
            end
            AR_GAP: begin
               if (!bga_s) begin
                  arb_ff   <= AR_GRANT;
               end else if (!br_s) begin
                  arb_ff   <= AR_OWNED;
                  grant_ff <= 1'b0;
               end
            end
         endcase
      end
   end

   // =========================================
   // Pin drive
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         away_ff   <= 1'b0;
         as_ff     <= 1'b0;
         ds_ff     <= 1'b0;
         doe_ff    <= 1'b0;
         int_stall <= 1'b0;
      end else begin
         away_ff   <= (arb_ff == AR_OWNED) || (arb_ff == AR_GAP) || bga_s;
         int_stall <= away_ff && (show_cycle_field == SHOW_ON_STALL);
         if (cyc_ff == CY_RUN && !away_ff && !int_ff && !bus_error_in_s && bus.transfer_acknowledge_n) begin
            as_ff  <= 1'b1;
            ds_ff  <= 1'b1;
            doe_ff <= wr_ff;
         end else if (cyc_ff == CY_RUN && int_ff && show_on && !away_ff) begin
            as_ff  <= 1'b0;
            ds_ff  <= 1'b1;
            doe_ff <= 1'b1;
         end else begin
            as_ff  <= 1'b0;
            ds_ff  <= 1'b0;
            doe_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         bus.address_strobe_n <= 1'b1;
         bus.data_strobe_n    <= 1'b1;
         bus.ctrl_oe_n        <= 1'b0;
         bus.data_oe_n        <= 1'b1;
         bus.addr             <= '0;
         bus.fc               <= '0;
         bus.size_lines       <= '0;
         bus.rd_wr            <= 1'b1;
         bus.data_out         <= '0;
         bus.locked_cycle_n   <= 1'b1;
         bus.bus_grant_n      <= 1'b1;
      end else begin
         bus.address_strobe_n <= !as_ff;
         bus.data_strobe_n    <= !ds_ff;
         bus.ctrl_oe_n        <= away_ff;
         bus.data_oe_n        <= !doe_ff || away_ff;
         bus.addr             <= addr_ff;
         bus.fc               <= fc_ff;
         bus.size_lines       <= siz_ff;
         bus.rd_wr            <= !wr_ff;
         bus.data_out         <= wdat_ff;
         bus.locked_cycle_n   <= !lock_ff;
         bus.bus_grant_n      <= !grant_ff;
      end
   end

   // =========================================
   // User side
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         req_ready  <= 1'b0;
         done       <= 1'b0;
         done_error <= 1'b0;
         rdata      <= '0;
         halted     <= 1'b0;
      end else begin
         req_ready  <= !busy_ff && !(req_valid && req_ready) && !int_stall;
         done       <= cyc_ff == CY_RUN && (int_ff || (!bus_error_in_s && !bus.transfer_acknowledge_n));
         done_error <= cyc_ff == CY_RUN && !int_ff && bus_error_in_s && !halt_s && !(br_s && lock_ff);
         if (cyc_ff == CY_RUN && !bus.transfer_acknowledge_n) begin
            rdata <= bus.data_in;
         end
         halted     <= (cyc_ff == CY_HALT) || double_fault;
      end
   end
endmodule
`default_nettype wire

// file: bra_pkg.sv
package bra_pkg;
   // =========================================
   // Widths
   localparam int ADDR_W = 24;
   localparam int DATA_W = 16;
   localparam int FC_W   = 3;
   localparam int SIZ_W  = 2;
   // =========================================
   // Size line encodings
   localparam logic [1:0] SIZ_BYTE = 2'h1;
   localparam logic [1:0] SIZ_WORD = 2'h2;
   // =========================================
   // Show cycle field encodings
   localparam logic [1:0] SHOW_OFF      = 2'h0;
   localparam logic [1:0] SHOW_ON       = 2'h2;
   localparam logic [1:0] SHOW_ON_STALL = 2'h3;
   // =========================================
   // Timing
   localparam int SYNC_DLY = 2;
   localparam logic [1:0] SYNC_DLY_CNT = 2'h2;
   localparam logic [1:0] GRANT_GAP    = 2'h2;
endpackage

// file: bra_if.sv
`timescale 1ns/100ps
`default_nettype none
interface bra_if;
   import bra_pkg::*;
   logic                address_strobe_n;
   logic                data_strobe_n;
   logic                ctrl_oe_n;
   logic [ADDR_W-1:0]   addr;
   logic [FC_W-1:0]     fc;
   logic [SIZ_W-1:0]    size_lines;
   logic                rd_wr;
   logic [DATA_W-1:0]   data_out;
   logic                data_oe_n;
   logic [DATA_W-1:0]   data_in;
   logic                locked_cycle_n;
   logic                transfer_acknowledge_n;
   logic                bus_error_in_n;
   logic                halt_n;
   logic                bus_request_n;
   logic                bus_grant_n;
   logic                grant_acknowledge_n;
   logic                factory_test_pin_n;
   modport dev (
      output address_strobe_n, data_strobe_n, ctrl_oe_n, addr, fc, size_lines, rd_wr,
             data_out, data_oe_n, locked_cycle_n, bus_grant_n,
      input  data_in, transfer_acknowledge_n, bus_error_in_n, halt_n, bus_request_n,
             grant_acknowledge_n, factory_test_pin_n
   );
   modport ext (
      input  address_strobe_n, data_strobe_n, ctrl_oe_n, addr, fc, size_lines, rd_wr,
             data_out, data_oe_n, locked_cycle_n, bus_grant_n,
      output data_in, transfer_acknowledge_n, bus_error_in_n, halt_n, bus_request_n,
             grant_acknowledge_n, factory_test_pin_n
   );
endinterface
`default_nettype wire

// file: bra_ext_master.sv
`timescale 1ns/100ps
`default_nettype none
module bra_ext_master (
   input  wire logic                       clk_sys,
   input  wire logic                       rstn,
   input  wire logic                       want_bus,
   input  wire logic                       term_ack,
   input  wire logic                       term_error,
   input  wire logic                       term_halt,
   input  wire logic                       term_retry_locked,
   input  wire logic                       test_mode,
   output logic                            own_bus,
   output logic                            wait_grant,
   bra_if.ext                              bus
);
   import bra_pkg::*;

   typedef enum logic [1:0] {EM_IDLE, EM_REQ, EM_OWN} bra_em_type;
   bra_em_type   st_ff;
   logic         bg_s1_ff;
   logic         bg_s2_ff;
   logic         bga_s1_ff;
   logic         bga_s2_ff;
   logic         lk_s1_ff;
   logic         lk_s2_ff;
   logic         ack_ff;
   logic         bus_error_in_ff;
   logic         halt_ff;

   // =========================================
   // Input synchronisers
   always_ff @(posedge clk_sys) begin
      bg_s1_ff  <= bus.bus_grant_n;
      bg_s2_ff  <= bg_s1_ff;
      bga_s1_ff <= bus.grant_acknowledge_n;
      bga_s2_ff <= bga_s1_ff;
      lk_s1_ff  <= bus.locked_cycle_n;
      lk_s2_ff  <= lk_s1_ff;
   end

   // =========================================
   // Mastership
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         st_ff <= EM_IDLE;
      end else begin
         unique case (st_ff)
            EM_IDLE: begin
               if (want_bus) begin
                  st_ff <= EM_REQ;
               end
            end
            EM_REQ: begin
               if (!bg_s2_ff && bga_s2_ff) begin
                  st_ff <= EM_OWN;
               end
            end
            EM_OWN: begin
               if (!want_bus) begin
                  st_ff <= EM_IDLE;
               end
            end
         endcase
      end
   end

   // =========================================
   // Termination
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         ack_ff  <= 1'b0;
         bus_error_in_ff <= 1'b0;
         halt_ff <= 1'b0;
      end else begin
         ack_ff <= term_ack && !bus.address_strobe_n;
         if (!lk_s2_ff && term_retry_locked) begin
            bus_error_in_ff <= 1'b1;
            halt_ff <= 1'b0;
         end else begin
            bus_error_in_ff <= term_error;
            halt_ff <= term_halt;
         end
      end
   end

   always_comb begin
      bus.bus_request_n          = !((st_ff == EM_REQ) || (st_ff == EM_IDLE && want_bus) ||
                                     (!lk_s2_ff && term_retry_locked));
      bus.grant_acknowledge_n    = !(st_ff == EM_OWN);
      bus.transfer_acknowledge_n = !ack_ff;
      bus.bus_error_in_n         = !bus_error_in_ff;
      bus.halt_n                 = !halt_ff;
      bus.factory_test_pin_n     = !test_mode;
      bus.data_in                = bus.addr[DATA_W-1:0];
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         own_bus    <= 1'b0;
         wait_grant <= 1'b0;
      end else begin
         own_bus    <= (st_ff == EM_OWN);
         wait_grant <= (st_ff == EM_REQ);
      end
   end
endmodule
`default_nettype wire

// file: bra_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module bra_asserts (
   input wire logic                       clk_sys,
   input wire logic                       rstn,
   input wire logic                       address_strobe_n,
   input wire logic                       data_strobe_n,
   input wire logic                       ctrl_oe_n,
   input wire logic                       data_oe_n,
   input wire logic [bra_pkg::SIZ_W-1:0]  size_lines,
   input wire logic [bra_pkg::DATA_W-1:0] data_out,
   input wire logic                       locked_cycle_n,
   input wire logic                       bus_error_in_n,
   input wire logic                       halt_n,
   input wire logic                       bus_request_n,
   input wire logic                       bus_grant_n,
   input wire logic                       grant_acknowledge_n
);
   import bra_pkg::*;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   // =========================================
   // Retry, halt and byte lanes
   property p_retry_stop;
      (!bus_error_in_n && !halt_n) [*5] |-> address_strobe_n && data_strobe_n;
   endproperty
   a_retry_stop:
      assert property (p_retry_stop) else $error("strobe active while retry held");
   property p_halt_float;
      (address_strobe_n && data_strobe_n && !halt_n) [*6] |-> data_oe_n;
   endproperty
   a_halt_float:
      assert property (p_halt_float) else $error("data driven while halted");
   property p_byte_lanes;
      (!address_strobe_n && !data_oe_n && size_lines == SIZ_BYTE) |-> data_out[15:8] == data_out[7:0];
   endproperty
   a_byte_lanes:
      assert property (p_byte_lanes) else $error("byte lanes differ");
   // =========================================
   // Arbitration
   property p_no_grant_locked;
      !locked_cycle_n |-> bus_grant_n;
   endproperty
   a_no_grant_locked:
      assert property (p_no_grant_locked) else $error("grant while locked");
   property p_grant_end;
      $fell(bus_grant_n) |-> address_strobe_n && locked_cycle_n;
   endproperty
   a_grant_end:
      assert property (p_grant_end) else $error("grant inside a transfer");
   property p_grant_drop;
      $fell(grant_acknowledge_n) |-> ##[1:6] bus_grant_n;
   endproperty
   a_grant_drop:
      assert property (p_grant_drop) else $error("grant kept after acknowledge");
   property p_idle;
      (bus_request_n && grant_acknowledge_n) [*5] |-> bus_grant_n;
   endproperty
   a_idle:
      assert property (p_idle) else $error("grant without request");
   property p_away_float;
      (!grant_acknowledge_n) [*5] |-> ctrl_oe_n && data_oe_n;
   endproperty
   a_away_float:
      assert property (p_away_float) else $error("driving while away");
   property p_sync;
      ($fell(bus_request_n) && bus_grant_n) |-> bus_grant_n [*2];
   endproperty
   a_sync:
      assert property (p_sync) else $error("grant before request synchronised");
endmodule
`default_nettype wire

// file: bus_retry_halt_arbiter_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module bus_retry_halt_arbiter_tb_top;
   import bra_pkg::*;
   // =========================================
   // Signals
   logic              clk_sys, rstn, req_valid, req_internal, req_write, req_locked, double_fault;
   logic              req_ready, done, done_error, halted, slave_mode, int_stall, own_bus, wait_grant;
   logic              want_bus, term_ack, term_error, term_halt, term_retry_locked, test_mode, ok, er;
   logic [ADDR_W-1:0] req_addr, seen_addr;
   logic [FC_W-1:0]   req_fc;
   logic [SIZ_W-1:0]  req_size;
   logic [DATA_W-1:0] req_wdata, rdata, seen_data;
   logic [1:0]        show_cycle_field;
   int                errors = 0, tests_run = 0, cyc = 0, n_as = 0, n_ds = 0;
   bra_if bra_if_i ();
   bra_ctrl bra_ctrl_i (.clk_sys, .rstn, .req_valid, .req_internal, .req_write, .req_locked, .req_addr,
      .req_fc, .req_size, .req_wdata, .show_cycle_field, .double_fault, .req_ready, .done, .done_error,
      .rdata, .halted, .slave_mode, .int_stall, .bus(bra_if_i));
   bra_ext_master bra_ext_master_i (.clk_sys, .rstn, .want_bus, .term_ack, .term_error, .term_halt,
      .term_retry_locked, .test_mode, .own_bus, .wait_grant, .bus(bra_if_i));
   bra_asserts bra_asserts_i (.clk_sys, .rstn, .address_strobe_n(bra_if_i.address_strobe_n),
      .data_strobe_n(bra_if_i.data_strobe_n), .ctrl_oe_n(bra_if_i.ctrl_oe_n),
      .data_oe_n(bra_if_i.data_oe_n), .size_lines(bra_if_i.size_lines), .data_out(bra_if_i.data_out),
      .locked_cycle_n(bra_if_i.locked_cycle_n), .bus_error_in_n(bra_if_i.bus_error_in_n),
      .halt_n(bra_if_i.halt_n), .bus_request_n(bra_if_i.bus_request_n),
      .bus_grant_n(bra_if_i.bus_grant_n), .grant_acknowledge_n(bra_if_i.grant_acknowledge_n));
   // =========================================
   // Clock and bus monitor
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (bra_if_i.data_strobe_n === 1'b0) seen_data <= bra_if_i.data_out;
      if (bra_if_i.address_strobe_n === 1'b0) begin
         n_as <= n_as + 1;
         seen_addr <= bra_if_i.addr;
      end else if (bra_if_i.data_strobe_n === 1'b0) begin
         n_ds <= n_ds + 1;
      end
      if (cyc == 20000) begin
         errors++;
         tally_and_finish();
      end
   end
   // =========================================
   // Shared tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t %s: got %0h expected %0h", $time, what, got, exp);
      end
   endtask
   task automatic cycle(input int n);
      repeat (n) @(posedge clk_sys);
      #2;
   endtask
   task automatic do_reset(input logic tm);
      test_mode = tm;
      rstn = 1'b0;
      cycle(4);
      rstn = 1'b1;
      cycle(3);
   endtask
   task automatic issue(input logic [2:0] kind, input logic [ADDR_W-1:0] a, input logic [SIZ_W-1:0] sz,
                        input logic [DATA_W-1:0] wd);
      int k;
      k = 0;
      {req_internal, req_write, req_locked} = kind;
      {req_addr, req_fc, req_size, req_wdata} = {a, a[2:0], sz, wd};
      req_valid = 1'b1;
      @(posedge clk_sys);
      while (req_ready !== 1'b1 && k < 400) begin
         @(posedge clk_sys);
         k++;
      end
      #2;
      req_valid = 1'b0;
      chk(k < 400, 1, "request taken");
   endtask
   task automatic wait_end(input int lim);
      ok = 1'b0;
      er = 1'b0;
      for (int k = 0; k < lim && !ok && !er; k++) begin
         @(posedge clk_sys);
         ok = (done === 1'b1);
         er = (done_error === 1'b1);
      end
      #2;
   endtask
   task automatic wait_own(input logic v);
      for (int k = 0; k < 60 && own_bus !== v; k++) cycle(1);
   endtask
   // =========================================
   // Scenarios
   task automatic t_slave();
      do_reset(1'b1);
      chk(slave_mode, 1, "slave mode");
      do_reset(1'b0);
      chk(slave_mode, 0, "normal mode");
   endtask
   task automatic t_byte_write();
      term_ack = 1'b1;
      issue(3'b010, 24'h01A2B4, SIZ_BYTE, 16'h5AC3);
      wait_end(50);
      chk(ok, 1, "write done");
      chk(seen_addr, 24'h01A2B4, "address");
      chk(seen_data, 16'hC3C3, "byte lanes");
   endtask
   task automatic t_retry();
      term_ack = 1'b0;
      issue(3'b010, 24'h00F0E0, SIZ_WORD, 16'hBEEF);
      cycle(4);
      chk(bra_if_i.address_strobe_n, 0, "cycle running");
      {term_error, term_halt} = 2'b11;
      wait_end(14);
      chk({ok, er}, 2'b00, "no end while retry held");
      chk(bra_if_i.address_strobe_n, 1, "strobe off");
      {seen_addr, seen_data} = '0;
      {term_ack, term_error, term_halt} = 3'b100;
      wait_end(50);
      chk(ok, 1, "rerun done");
      chk(seen_addr, 24'h00F0E0, "rerun address");
      chk(seen_data, 16'hBEEF, "rerun data");
      {term_ack, term_error} = 2'b01;
      issue(3'b000, 24'h000100, SIZ_WORD, 16'h0000);
      wait_end(50);
      chk(er, 1, "error without halt");
      term_error = 1'b0;
      term_ack = 1'b1;
      cycle(4);
   endtask
   task automatic t_halt();
      term_halt = 1'b1;
      issue(3'b000, 24'h002468, SIZ_WORD, 16'h0000);
      wait_end(50);
      chk(ok, 1, "cycle ends under halt");
      chk(rdata, 16'h2468, "read data");
      cycle(4);
      chk(halted, 1, "halted");
      chk({bra_if_i.address_strobe_n, bra_if_i.data_strobe_n, bra_if_i.data_oe_n}, 3'b111, "quiet");
      chk(bra_if_i.addr, 24'h002468, "address held");
      want_bus = 1'b1;
      wait_own(1'b1);
      cycle(4);
      chk(bra_if_i.ctrl_oe_n, 1, "floated while away");
      want_bus = 1'b0;
      wait_own(1'b0);
      cycle(6);
      chk({bra_if_i.ctrl_oe_n, bra_if_i.addr}, {1'b0, 24'h002468}, "address restored");
      n_as = 0;
      issue(3'b100, 24'hFFF000, SIZ_WORD, 16'h0000);
      wait_end(50);
      chk({ok, n_as[7:0]}, {1'b1, 8'h00}, "internal runs while halted");
      fork
         begin
            issue(3'b000, 24'h003000, SIZ_WORD, 16'h0000);
            wait_end(60);
         end
         begin
            cycle(10);
            chk(n_as, 0, "no external cycle while halted");
            term_halt = 1'b0;
         end
      join
      chk(ok, 1, "stepped after release");
   endtask
   task automatic t_show();
      {n_as, n_ds} = '0;
      show_cycle_field = SHOW_ON;
      issue(3'b110, 24'hFFF010, SIZ_WORD, 16'h1357);
      wait_end(50);
      cycle(2);
      chk({ok, n_as[7:0], n_ds != 0}, {1'b1, 8'h00, 1'b1}, "show cycle strobes");
      chk(seen_data, 16'h1357, "show data");
      show_cycle_field = SHOW_OFF;
      n_ds = 0;
      issue(3'b110, 24'hFFF020, SIZ_WORD, 16'h2468);
      wait_end(50);
      cycle(2);
      chk({ok, n_as[7:0], n_ds[7:0]}, {1'b1, 8'h00, 8'h00}, "no show strobes");
   endtask
   task automatic t_arb();
      issue(3'b001, 24'h004000, SIZ_WORD, 16'h0000);
      wait_end(50);
      want_bus = 1'b1;
      cycle(12);
      chk(own_bus, 0, "no grant while locked");
      chk(wait_grant, 1, "request pending while locked");
      issue(3'b011, 24'h004000, SIZ_WORD, 16'hA5A5);
      req_locked = 1'b0;
      wait_end(50);
      double_fault = 1'b1;
      wait_own(1'b1);
      chk(halted, 1, "halted on double fault");
      chk(own_bus, 1, "granted after lock and on double fault");
      want_bus = 1'b0;
      wait_own(1'b0);
      double_fault = 1'b0;
      cycle(6);
      issue(3'b000, 24'h005000, SIZ_WORD, 16'h0000);
      wait_end(50);
      chk(ok, 1, "cycle after bus returned");
      chk(rdata, 16'h5000, "read after bus returned");
   endtask
   task automatic tally_and_finish();
      if (errors == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // =========================================
   // Main sequence
   initial begin
      {req_valid, req_internal, req_write, req_locked, double_fault} = '0;
      {want_bus, term_ack, term_error, term_halt, term_retry_locked} = '0;
      {req_addr, req_fc, req_size, req_wdata, show_cycle_field} = '0;
      t_slave();
      t_byte_write();
      t_retry();
      t_halt();
      t_show();
      t_arb();
      tally_and_finish();
   end
endmodule
`default_nettype wire
